// file: design/exv_ctrl.sv
// Purpose: Reset, trap and interrupt sequencing with vector selection.
// Assumes: Core gives boundary pulses, mask bit, trap and sleep pulses.
// Notes:   Vector offered on o_vec_valid stands until i_vec_ack, i_wdt_ovf or the reset pin going low.
`timescale 1ns/1ps
`include "exv_map.svh"

module exv_ctrl
(
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_reset_pin_n,
  input  wire logic             i_wdt_ovf,
  input  wire logic             i_boundary,
  input  wire logic             i_imask,
  input  wire logic             i_trap,
  input  wire logic [1:0]       i_trap_op,
  input  wire logic             i_sleep_dt,
  input  wire exv_pkg::exv_src_t i_src,
  input  wire logic             i_vec_ack,
  output logic                  o_core_rst,
  output logic                  o_vec_valid,
  output exv_pkg::exv_vec_t     o_vec
);

  // ===================================================================
  // Pin synchroniser
  logic                pin_meta;
  logic                pin_sync;

  // The pin is asynchronous; only pin_sync feeds logic.
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
    end
    else
    begin
      pin_meta <= i_reset_pin_n;
      pin_sync <= pin_meta;
    end
  end

  // ===================================================================
  // Request vector, indexed by vector number
  logic [`EXV_NUM_VEC-1:0] req;
  logic                    trap_pend;
  logic [1:0]              trap_num;
  logic                    sleep_pend;
  logic                    mask_ok;

  always_comb
  begin
    req = '0;
    // Mask gate
    // Mask gates maskables.
    mask_ok = ~i_imask;
    req[`EXV_VEC_NMI]    = i_src.nmi;
    req[`EXV_VEC_ABRK]   = i_src.addr_break;
    // Trap vectors
    // Operand picks vector.
    req[`EXV_VEC_TRAP_BASE + {4'h0, trap_num}] = trap_pend;
    req[`EXV_VEC_SLEEP]  = sleep_pend & mask_ok;
    req[`EXV_VEC_EXT_LINE_0] = mask_ok & (i_src.external_request_line_0 |
                           (i_src.low_volt & `EXV_LVD_PRESENT));
    req[`EXV_VEC_IRQ1]   = mask_ok & i_src.irq1;
    req[`EXV_VEC_IRQ2]   = mask_ok & i_src.irq2;
    req[`EXV_VEC_IRQ3]   = mask_ok & i_src.irq3;
    req[`EXV_VEC_WAKEUP] = mask_ok & i_src.wakeup;
    req[`EXV_VEC_CLK_OVF] = mask_ok & i_src.clk_ovf;
    req[`EXV_VEC_TMR8]   = mask_ok & (|i_src.tmr8);
    req[`EXV_VEC_SER1]   = mask_ok & (|i_src.ser1);
    req[`EXV_VEC_TWI]    = mask_ok & (|i_src.twi);
    req[`EXV_VEC_ADC]    = mask_ok & i_src.adc;
    req[`EXV_VEC_MTMR0]  = mask_ok & i_src.mtmr0;
    req[`EXV_VEC_MTMR1]  = mask_ok & i_src.mtmr1;
    req[`EXV_VEC_ITEM_A] = mask_ok & i_src.item_a;
    req[`EXV_VEC_SER2]   = mask_ok & (|i_src.ser2);
  end

  // ===================================================================
  // Priority encoder
  logic       win_any;
  logic [5:0] win_num;

  // Scan from the top so the lowest number is left standing.
  // Lowest number wins.
  always_comb
  begin
    win_any = 1'b0;
    win_num = 6'h00;
    for (int k = `EXV_NUM_VEC - 1; k >= 0; k--)
    begin
      if (req[k])
      begin
        win_any = 1'b1;
        win_num = 6'(k);
      end
    end
  end

  // ===================================================================
  // Sequencer
  exv_pkg::exv_state_t state;
  exv_pkg::exv_state_t next_state;
  logic                next_vec_valid;
  logic [5:0]          next_vec_num;
  logic                next_trap_pend;
  logic [1:0]          next_trap_num;
  logic                next_sleep_pend;
  logic                taken;
  logic [5:0]          vec_num;

  // A trap or sleep pulse in the cycle its latch clears is kept:
  // setting is applied after the clear.
  always_comb
  begin
    next_state      = state;
    next_vec_valid  = o_vec_valid;
    next_vec_num    = vec_num;
    next_trap_pend  = trap_pend;
    next_trap_num   = trap_num;
    next_sleep_pend = sleep_pend;
    taken           = o_vec_valid & i_vec_ack;
    if (taken && vec_num >= `EXV_VEC_TRAP_BASE &&
        vec_num <= `EXV_VEC_TRAP_BASE + 6'h03)
      next_trap_pend = 1'b0;
    if (taken && vec_num == `EXV_VEC_SLEEP)
      next_sleep_pend = 1'b0;
    if (i_trap)
    begin
      next_trap_pend = 1'b1;
      next_trap_num  = i_trap_op;
    end
    if (i_sleep_dt)
      next_sleep_pend = 1'b1;
    if (taken)
      next_vec_valid = 1'b0;
    unique case (state)
      exv_pkg::EXV_HOLD:
      begin
        next_vec_valid = 1'b0;
        if (pin_sync)
          next_state = exv_pkg::EXV_RSTV;
      end
      exv_pkg::EXV_RSTV:
      begin
        next_vec_valid  = ~taken;
        next_vec_num    = `EXV_VEC_RESET;
        next_trap_pend  = 1'b0;
        next_sleep_pend = 1'b0;
        if (taken)
          next_state = exv_pkg::EXV_RUN;
      end
      exv_pkg::EXV_RUN:
      begin
        if (i_boundary && !o_vec_valid && win_any)
        begin
          next_vec_valid = 1'b1;
          next_vec_num   = win_num;
        end
      end
    endcase
    if (!pin_sync || i_wdt_ovf)
    begin
      next_state      = exv_pkg::EXV_HOLD;
      next_vec_valid  = 1'b0;
      next_trap_pend  = 1'b0;
      next_sleep_pend = 1'b0;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      state       <= exv_pkg::EXV_HOLD;
      o_vec_valid <= 1'b0;
      vec_num     <= 6'h00;
      trap_pend   <= 1'b0;
      trap_num    <= 2'h0;
      sleep_pend  <= 1'b0;
    end
    else
    begin
      state       <= next_state;
      o_vec_valid <= next_vec_valid;
      vec_num     <= next_vec_num;
      trap_pend   <= next_trap_pend;
      trap_num    <= next_trap_num;
      sleep_pend  <= next_sleep_pend;
    end
  end

  // ===================================================================
  // Outputs
  // Entry at twice number.
  assign o_vec = '{num:  vec_num,
                   addr: {9'h000, vec_num, 1'b0}};
  // Core is held while the sequencer sits in the hold state.
  assign o_core_rst = (state == exv_pkg::EXV_HOLD);

endmodule : exv_ctrl

// file: design/exv_map.svh
// Purpose: Constants for the exception vector and priority unit.
// Assumes: Vector numbers 0..32, two-byte vector table entries.
// Notes:   Vector numbers and table size live here as macros; trap span and entry shift are literals in the design.
`ifndef EXV_MAP_SVH
`define EXV_MAP_SVH

// =====================================================================
// Vector numbers
`define EXV_VEC_RESET      6'h00
`define EXV_VEC_NMI        6'h07
`define EXV_VEC_TRAP_BASE  6'h08
`define EXV_VEC_ABRK       6'h0c
`define EXV_VEC_SLEEP      6'h0d
`define EXV_VEC_EXT_LINE_0 6'h0e
`define EXV_VEC_IRQ1       6'h0f
`define EXV_VEC_IRQ2       6'h10
`define EXV_VEC_IRQ3       6'h11
`define EXV_VEC_WAKEUP     6'h12
`define EXV_VEC_CLK_OVF    6'h13
`define EXV_VEC_TMR8       6'h16
`define EXV_VEC_SER1       6'h17
`define EXV_VEC_TWI        6'h18
`define EXV_VEC_ADC        6'h19
`define EXV_VEC_MTMR0      6'h1a
`define EXV_VEC_MTMR1      6'h1b
`define EXV_VEC_ITEM_A     6'h1d
`define EXV_VEC_SER2       6'h20

// =====================================================================
// Table geometry and low-voltage option
`define EXV_NUM_VEC        33
`define EXV_ENTRY_SHIFT    1
`define EXV_LVD_PRESENT    1'b1

`endif

// file: design/exv_pkg.sv
// Purpose: Types shared by the exception vector and priority unit.
// Assumes: Source flags are on-chip levels on the system clock.
// Notes:   Grouped event bits are ORed inside the unit.
package exv_pkg;

  // ===================================================================
  // Interrupt source bundle
  typedef struct packed {
    logic       nmi;         // Nonmaskable pin interrupt.
    logic       addr_break;  // Address-break condition met.
    logic       external_request_line_0; // External request line 0.
    logic       low_volt;    // Low-voltage detection.
    logic       irq1;
    logic       irq2;
    logic       irq3;
    logic       wakeup;      // Wakeup pin interrupt, any pin.
    logic       clk_ovf;     // Clock counter overflow.
    logic [2:0] tmr8;        // Compare A, compare B, overflow.
    logic [3:0] ser1;        // Rx full, tx empty, tx end, rx error.
    logic [5:0] twi;         // Two-wire bus interface events.
    logic       adc;         // Converter done.
    logic       mtmr0;       // Multi-channel timer group 0.
    logic       mtmr1;       // Multi-channel timer group 1.
    logic       item_a;      // Second free-running timer overflow.
    logic [3:0] ser2;        // Second serial channel events.
  } exv_src_t;

  // ===================================================================
  // Vector handed to the core
  typedef struct packed {
    logic [5:0]  num;
    logic [15:0] addr;
  } exv_vec_t;

  // ===================================================================
  // Sequencer states, one-hot
  typedef enum logic [2:0] {
    EXV_HOLD = 3'b001,
    EXV_RSTV = 3'b010,
    EXV_RUN  = 3'b100
  } exv_state_t;

endpackage : exv_pkg

// file: tb/exv_ctrl_properties.sv
// Purpose: Port checks for the exception vector unit.
// Assumes: One clock domain, i_rst disables the checks.
// Notes:   Bound to exv_ctrl from the bench top file.
`timescale 1ns/1ps
module exv_ctrl_properties
(
  input wire logic              i_clk,
  input wire logic              i_rst,
  input wire logic              i_reset_pin_n,
  input wire logic              i_wdt_ovf,
  input wire logic              i_boundary,
  input wire logic              i_imask,
  input wire exv_pkg::exv_src_t i_src,
  input wire logic              i_vec_ack,
  input wire logic              o_core_rst,
  input wire logic              o_vec_valid,
  input wire exv_pkg::exv_vec_t o_vec
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  // ==================================================================
  // Sequences
  // A boundary that the unit may take. A watchdog pulse, a pin that went
  // low a cycle ago or the first cycle of the reset vector would win.
  sequence s_take;
    i_boundary && !o_vec_valid && !o_core_rst && !i_wdt_ovf &&
      !$past(o_core_rst) && $past(i_reset_pin_n);
  endsequence
  sequence s_stand;
    o_vec_valid && !i_vec_ack && !i_wdt_ovf && $past(i_reset_pin_n);
  endsequence
  // ==================================================================
  // Assertions
  a_vec_stands: // held until ack
    assert property (s_stand |=> o_vec_valid && $stable(o_vec))
    else $error("vector changed before ack");
  a_ack_drop: // drop after ack
    assert property (o_vec_valid && i_vec_ack |=> !o_vec_valid)
    else $error("vector stayed after ack");
  a_addr_twice: // address is twice
    assert property (o_vec_valid |-> o_vec.addr == {9'h0, o_vec.num, 1'b0})
    else $error("vector address not twice number");
  a_boundary_only: // taken at boundary
    assert property ($rose(o_vec_valid) |->
      $past(i_boundary) || o_vec.num == 6'h00)
    else $error("vector offered without boundary");
  a_pin_holds: // pin low holds
    assert property (!i_reset_pin_n [*3] |=> o_core_rst && !o_vec_valid)
    else $error("core ran while pin low");
  a_wdt_resets: // watchdog resets
    assert property (i_wdt_ovf |-> ##[1:2] o_core_rst && !o_vec_valid)
    else $error("watchdog did not reset");
  a_mask_hold: // mask holds off
    assert property (s_take ##0 i_imask |=>
      !o_vec_valid || o_vec.num inside {[6'h07:6'h0c]})
    else $error("masked source taken");
  a_nmi_first: // nonmaskable wins
    assert property (s_take ##0 i_src.nmi |=>
      o_vec_valid && o_vec.num == 6'h07)
    else $error("nonmaskable not first");
endmodule : exv_ctrl_properties

// file: tb/exv_core_model.sv
// Purpose: Core side that accepts offered vectors.
// Assumes: Acknowledge is registered and high for one edge.
// Notes:   i_wait sets how long the core lets a vector stand.
`timescale 1ns/1ps
module exv_core_model
(
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_vec_valid,
  input  wire logic [2:0] i_wait,
  output logic            o_vec_ack
);
  logic [2:0] cnt;
  // ==================================================================
  // Acknowledge
  // Ack drops after the edge that sees it, so no vector is taken twice.
  always_ff @(posedge i_clk)
  begin
    if (i_rst || o_vec_ack || !i_vec_valid)
    begin
      o_vec_ack <= 1'b0;
      cnt       <= 3'h0;
    end
    else if (cnt == i_wait)
      o_vec_ack <= 1'b1;
    else
      cnt <= cnt + 3'h1;
  end
endmodule : exv_core_model

// file: tb/tb.sv
// Purpose: Self-checking bench for the exception vector unit.
// Assumes: Inputs change on the falling edge of i_clk.
// Notes:   A bench model picks the winning vector number.
`timescale 1ns/1ps
module tb;
  logic              i_clk = 1'b0;
  logic              i_rst = 1'b1;
  logic              i_reset_pin_n = 1'b0;
  logic              i_wdt_ovf = 1'b0;
  logic              i_boundary = 1'b0;
  logic              i_imask = 1'b0;
  logic              i_trap = 1'b0;
  logic [1:0]        i_trap_op = 2'h0;
  logic              i_sleep_dt = 1'b0;
  exv_pkg::exv_src_t i_src = '0;
  logic              i_vec_ack;
  logic              o_core_rst;
  logic              o_vec_valid;
  exv_pkg::exv_vec_t o_vec;
  logic [2:0]        ack_wait = 3'h0;
  int                n_errors = 0;
  int                n_tests = 0;
  int                seed = 17;
  int                cycles = 0;
  int                trap_num = 0;
  int                exp;
  int                r;
  bit                trap_pend = 0;
  bit                sleep_pend = 0;
  always #20 i_clk = ~i_clk;
  exv_ctrl dut (.i_clk, .i_rst, .i_reset_pin_n, .i_wdt_ovf, .i_boundary,
    .i_imask, .i_trap, .i_trap_op, .i_sleep_dt, .i_src, .i_vec_ack,
    .o_core_rst, .o_vec_valid, .o_vec);
  exv_core_model core (.i_clk, .i_rst, .i_vec_valid(o_vec_valid),
    .i_wait(ack_wait), .o_vec_ack(i_vec_ack));
  // ==================================================================
  // Model and checks
  // Lowest pending number wins; traps and nonmaskables ignore the mask.
  function automatic int pick(exv_pkg::exv_src_t s, bit m);
    logic [32:0] p;
    p = {{|s.ser2, 2'h0, s.item_a, 1'h0, s.mtmr1, s.mtmr0, s.adc, |s.twi,
      |s.ser1, |s.tmr8, 2'h0, s.clk_ovf, s.wakeup, s.irq3, s.irq2, s.irq1,
      s.external_request_line_0 | s.low_volt, sleep_pend} & {20{!m}},
      13'h0};
    p[7] = s.nmi;
    p[12] = s.addr_break;
    if (trap_pend)
      p[8 + trap_num] = 1'b1;
    for (int k = 0; k < 33; k++)
      if (p[k])
        return k;
    return -1;
  endfunction : pick
  task automatic chk_vec(int n);
    exv_pkg::exv_vec_t e;
    e = '{num: n[5:0], addr: 16'(2 * n)};
    n_tests++;
    if (o_vec !== e)
    begin
      n_errors++;
      $display("ERROR %0t got %h exp %h", $time, o_vec, e);
    end
  endtask : chk_vec
  task automatic chk_bit(logic got, logic e);
    n_tests++;
    if (got !== e)
    begin
      n_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, e);
    end
  endtask : chk_bit
  task automatic wait_lvl(ref logic s, input logic v);
    for (int k = 0; k < 40 && s !== v; k++)
      @(negedge i_clk);
  endtask : wait_lvl
  task automatic close_out();
    if (n_errors == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out
  // A hang is cut short and counted.
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      close_out();
    end
  end
  // ==================================================================
  // Sequence
  initial
  begin
    repeat (2) @(negedge i_clk);
    i_rst = 1'b0;
    repeat (4) @(negedge i_clk);
    chk_bit(o_core_rst, 1'b1); // Pin still low.
    i_reset_pin_n = 1'b1;
    wait_lvl(o_vec_valid, 1'b1);
    chk_vec(0); // Reset slot.
    wait_lvl(o_core_rst, 1'b0);
    wait_lvl(o_vec_valid, 1'b0);
    for (int i = 0; i < 200; i++)
    begin
      r = $random(seed);
      ack_wait = r[2:0];
      i_imask = r[3];
      i_trap = r[4] & !trap_pend;
      i_trap_op = r[6:5];
      i_sleep_dt = r[7];
      sleep_pend |= r[7];
      if (i_trap)
        trap_num = r[6:5];
      trap_pend |= i_trap;
      r = $random(seed) & $random(seed) & $random(seed);
      i_src = r[29:0];
      @(negedge i_clk);
      i_trap = 1'b0;
      i_sleep_dt = 1'b0;
      i_boundary = 1'b1;
      exp = pick(i_src, i_imask);
      @(negedge i_clk);
      i_boundary = 1'b0;
      if (exp < 0)
      begin
        repeat (3) @(negedge i_clk);
        chk_bit(o_vec_valid, 1'b0); // Held off.
      end
      else
      begin
        wait_lvl(o_vec_valid, 1'b1);
        chk_vec(exp);
        chk_vec(exp);
        wait_lvl(o_vec_valid, 1'b0);
      end
      i_src = '0;
      trap_pend &= !(exp >= 8 && exp <= 11);
      sleep_pend &= exp != 13;
    end
    ack_wait = 3'h7;
    i_src.nmi = 1'b1;
    i_boundary = 1'b1;
    @(negedge i_clk);
    i_boundary = 1'b0;
    wait_lvl(o_vec_valid, 1'b1);
    i_wdt_ovf = 1'b1;
    @(negedge i_clk);
    i_wdt_ovf = 1'b0;
    i_src = '0;
    chk_bit(o_core_rst, 1'b1); // Watchdog reset.
    wait_lvl(o_vec_valid, 1'b1);
    chk_vec(0); // Reset slot again.
    close_out();
  end
endmodule : tb
bind exv_ctrl exv_ctrl_properties u_prop (.i_clk, .i_rst, .i_reset_pin_n,
  .i_wdt_ovf, .i_boundary, .i_imask, .i_src, .i_vec_ack, .o_core_rst,
  .o_vec_valid, .o_vec);
